// File: tick_map.svh
/*
 * Register map, field positions, reset values and timing counts of the
 * PLL modulation control and periodic tick timer block.
 * Assumes an APB slave with 32-bit data and 12-bit byte addresses.
 */
`ifndef TICK_MAP_SVH
`define TICK_MAP_SVH

// Register indices; each register sits at four times its index
`define PMC_IDX 12'h00a
`define TRC_IDX 12'h00b
`define CSR_IDX 12'h020
`define IST_IDX 12'h021
`define IMK_IDX 12'h022
`define PMC_ADDR (`PMC_IDX << 2)
`define TRC_ADDR (`TRC_IDX << 2)
`define CSR_ADDR (`CSR_IDX << 2)
`define IST_ADDR (`IST_IDX << 2)
`define IMK_ADDR (`IMK_IDX << 2)

// Reset values
`define PMC_RESET 8'h00
`define TRC_RESET 8'h00
`define CSR_RESET 4'h0
`define IMK_RESET 2'h0

// pll_modulation_control fields
`define FM_HI_BIT 5
`define FM_LO_BIT 4

// tick_rate_control fields
`define DEC_BIT 7
`define PRE_MSB 6
`define PRE_LSB 4
`define MOD_MSB 3
`define MOD_LSB 0

// clock_select_register fields
`define CSR_TICK_SEL 0
`define CSR_PSTOP 1
`define CSR_REGISTER_PROTECT 2
`define CSR_PLL_SEL 3

// Interrupt status and mask bits, then read-only flags
`define IST_TICK 0
`define IST_OSC_LOST 1
`define IST_LOCK 2
`define IST_OSC_UP 3

// Modulation runs at reference / 16: phase flips every 8 reference edges
`define FM_HALF_LAST 3'h7
// Binary prescaler exponent is code plus this offset
`define BIN_EXP_OFFSET 5'h09

`endif

// File: tick_pkg.sv
/*
 * Types shared by the tick timer and PLL modulation control block.
 * Assumes nothing of its surroundings.
 */
package tick_pkg;

    typedef enum logic [1:0]
    {
        FM_OFF  = 2'b00,
        FM_1PCT = 2'b01,
        FM_2PCT = 2'b10,
        FM_4PCT = 2'b11
    } fm_amp_t;

    typedef enum logic [1:0]
    {
        TICK_OFF  = 2'b00,
        TICK_RUN  = 2'b01,
        TICK_HALT = 2'b10
    } tick_mode_t;

endpackage

// File: pin_sync.sv
/*
 * Three-stage synchroniser for a level from another clock domain.
 * A change is taken once the second and third stages agree.
 * Assumes clk_i is the block clock and nrst_i its synchronous reset.
 */
`timescale 1ns/10ps
module pin_sync
#(
    parameter logic RESET_VALUE = 1'b0
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Asynchronous level
    input wire logic pin_i,
    // Filtered level and change pulses
    output logic level_o,
    output logic rise_o,
    output logic fall_o
);

    logic stage1;
    logic stage2;
    logic stage3;
    logic next_level;

    always_comb
    begin
        next_level = level_o;
        if (stage2 == stage3)
        begin
            next_level = stage3;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            stage1 <= RESET_VALUE;
            stage2 <= RESET_VALUE;
            stage3 <= RESET_VALUE;
            level_o <= RESET_VALUE;
        end
        else
        begin
            stage1 <= pin_i;
            stage2 <= stage1;
            stage3 <= stage2;
            level_o <= next_level;
        end
    end

    assign rise_o = next_level & ~level_o;
    assign fall_o = ~next_level & level_o;

endmodule // pin_sync

// File: tick_pll_ctrl.sv
/*
 * PLL frequency modulation control and periodic tick timer, APB slave.
 * Assumes the RC, crystal and PLL reference clocks and the lock and
 * oscillator-ready levels arrive asynchronously; stop_mode_i is on clk_i.
 */
// Chosen here: the APB interface to the registers.
// Operation
// - PLL modulation writes only land when protection clear and PLL selected.
// - Any PLL modulation register write clears lock and oscillator-up flags.
// - Enabled modulation runs at PLL reference frequency divided by sixteen.
// - Amplitude bits 5:4 pick off, one, two or four percent.
// - Tick clock is RC clock or crystal clock per select bit.
// - In stop mode tick counts only with pseudo stop and crystal clock.
// - Tick rate register read and written anytime, unprotected.
// - Every tick rate write restarts the timeout period.
// - Changing tick clock select or losing oscillator-up restarts the period.
// - Bit 7 picks binary prescaler when clear, decimal when set.
// - Binary prescale code zero is off; 1 to 7 give 2^10..2^16.
// - Modulus bits 3:0 multiply prescaler by field plus one.
// - All-zero setting is reset default and stops the tick timer.
// - Decimal codes select 1,2,5,10,20,50,100,200 thousand times modulus.
`timescale 1ns/10ps
`include "tick_map.svh"
module tick_pll_ctrl
    import tick_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // APB slave
    input wire logic [11:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Clock sources and unit status
    input wire logic internal_rc_clock_i,
    input wire logic crystal_osc_clock_i,
    input wire logic pll_ref_clock_i,
    input wire logic osc_ready_i,
    input wire logic pll_lock_i,
    input wire logic stop_mode_i,
    // Modulation, tick, interrupt and status outputs
    output logic [1:0] fm_amplitude_o,
    output logic fm_phase_o,
    output logic tick_event_o,
    output logic irq_o,
    output logic pll_locked_o,
    output logic osc_up_flag_o
);

    // Synchronised sources
    logic irc_level;
    logic irc_rise;
    logic osc_level;
    logic osc_rise;
    logic ref_level;
    logic ref_rise;
    logic oscrdy_level;
    logic oscrdy_rise;
    logic oscrdy_fall;
    logic lock_level;
    logic lock_rise;
    logic lock_fall;

    pin_sync #(.RESET_VALUE(1'b0)) u_sync_irc
    (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .pin_i(internal_rc_clock_i),
        .level_o(irc_level),
        .rise_o(irc_rise),
        .fall_o()
    );

    pin_sync #(.RESET_VALUE(1'b0)) u_sync_osc
    (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .pin_i(crystal_osc_clock_i),
        .level_o(osc_level),
        .rise_o(osc_rise),
        .fall_o()
    );

    pin_sync #(.RESET_VALUE(1'b0)) u_sync_ref
    (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .pin_i(pll_ref_clock_i),
        .level_o(ref_level),
        .rise_o(ref_rise),
        .fall_o()
    );

    pin_sync #(.RESET_VALUE(1'b0)) u_sync_oscrdy
    (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .pin_i(osc_ready_i),
        .level_o(oscrdy_level),
        .rise_o(oscrdy_rise),
        .fall_o(oscrdy_fall)
    );

    pin_sync #(.RESET_VALUE(1'b0)) u_sync_lock
    (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .pin_i(pll_lock_i),
        .level_o(lock_level),
        .rise_o(lock_rise),
        .fall_o(lock_fall)
    );

    // Register state
    logic [7:0] pll_modulation_control;
    logic [7:0] tick_rate_control;
    logic [3:0] clock_select_register;
    logic [1:0] irq_mask;
    logic [1:0] irq_status;
    logic lock_flag;
    logic osc_flag;
    logic [7:0] next_pll_modulation_control;
    logic [7:0] next_tick_rate_control;
    logic [3:0] next_clock_select_register;
    logic [1:0] next_irq_mask;
    logic [1:0] next_irq_status;
    logic next_lock_flag;
    logic next_osc_flag;
    logic [31:0] next_prdata;

    // Bus decode
    logic setup_phase;
    logic wr_access;
    logic rd_access;
    logic pll_wr_req;
    logic tick_wr;
    logic csr_wr;
    logic status_rd;
    logic addr_hit;
    logic osc_lost;
    logic sel_changed;

    // Tick timer
    logic [21:0] tick_cnt;
    logic [21:0] next_tick_cnt;
    logic [21:0] tick_target;
    logic [17:0] tick_base;
    logic next_tick_event;
    logic tick_src_edge;
    logic tick_restart;
    tick_mode_t tick_mode;

    // Modulation
    logic [2:0] fm_div;
    logic [2:0] next_fm_div;
    logic next_fm_phase;

    logic tick_clock_select;
    logic pseudo_stop_select;
    logic register_protect;
    logic pll_clock_select;

    assign tick_clock_select = clock_select_register[`CSR_TICK_SEL];
    assign pseudo_stop_select = clock_select_register[`CSR_PSTOP];
    assign register_protect = clock_select_register[`CSR_REGISTER_PROTECT];
    assign pll_clock_select = clock_select_register[`CSR_PLL_SEL];

    assign setup_phase = psel_i & ~penable_i;
    assign wr_access = psel_i & penable_i & pwrite_i & pstrb_i[0];
    assign rd_access = psel_i & penable_i & ~pwrite_i;
    assign pll_wr_req = wr_access & (paddr_i == `PMC_ADDR);
    assign tick_wr = wr_access & (paddr_i == `TRC_ADDR);
    assign csr_wr = wr_access & (paddr_i == `CSR_ADDR);
    assign status_rd = rd_access & (paddr_i == `IST_ADDR);
    assign addr_hit = (paddr_i == `PMC_ADDR) | (paddr_i == `TRC_ADDR) | (paddr_i == `CSR_ADDR)
                    | (paddr_i == `IST_ADDR) | (paddr_i == `IMK_ADDR);

    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~addr_hit;

    // Register and flag updates
    always_comb
    begin
        next_pll_modulation_control = pll_modulation_control;
        next_tick_rate_control = tick_rate_control;
        next_clock_select_register = clock_select_register;
        next_irq_mask = irq_mask;
        next_prdata = prdata_o;
        if (pll_wr_req && !register_protect && pll_clock_select)
        begin
            next_pll_modulation_control = {2'b00, pwdata_i[`FM_HI_BIT:`FM_LO_BIT], 4'h0};
        end
        if (tick_wr)
        begin
            next_tick_rate_control = pwdata_i[7:0];
        end
        if (csr_wr)
        begin
            next_clock_select_register = pwdata_i[3:0];
            // Crystal source only while oscillator is up
            next_clock_select_register[`CSR_TICK_SEL] = pwdata_i[`CSR_TICK_SEL] & osc_flag;
        end
        if (osc_lost)
        begin
            next_clock_select_register[`CSR_TICK_SEL] = 1'b0;
        end
        if (wr_access && paddr_i == `IMK_ADDR)
        begin
            next_irq_mask = pwdata_i[1:0];
        end
        // Set beats clear: oscillator and lock flags
        next_osc_flag = oscrdy_rise | (osc_flag & ~pll_wr_req & ~oscrdy_fall);
        next_lock_flag = lock_rise | (lock_flag & ~pll_wr_req & ~lock_fall);
        // Read clears only what was returned; new events survive
        next_irq_status = irq_status;
        if (status_rd)
        begin
            next_irq_status = irq_status & ~prdata_o[1:0];
        end
        next_irq_status[`IST_TICK] = next_irq_status[`IST_TICK] | next_tick_event;
        next_irq_status[`IST_OSC_LOST] = next_irq_status[`IST_OSC_LOST] | osc_lost;
        // Read data captured in the setup cycle
        if (setup_phase)
        begin
            unique case (paddr_i)
                `PMC_ADDR: next_prdata = {24'h000000, pll_modulation_control};
                `TRC_ADDR: next_prdata = {24'h000000, tick_rate_control};
                `CSR_ADDR: next_prdata = {28'h0000000, clock_select_register};
                `IST_ADDR: next_prdata = {28'h0000000, osc_flag, lock_flag, irq_status};
                `IMK_ADDR: next_prdata = {30'h00000000, irq_mask};
                default: next_prdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            pll_modulation_control <= `PMC_RESET;
            tick_rate_control <= `TRC_RESET;
            clock_select_register <= `CSR_RESET;
            irq_mask <= `IMK_RESET;
            irq_status <= 2'h0;
            osc_flag <= 1'b0;
            lock_flag <= 1'b0;
            prdata_o <= 32'h00000000;
        end
        else
        begin
            pll_modulation_control <= next_pll_modulation_control;
            tick_rate_control <= next_tick_rate_control;
            clock_select_register <= next_clock_select_register;
            irq_mask <= next_irq_mask;
            irq_status <= next_irq_status;
            osc_flag <= next_osc_flag;
            lock_flag <= next_lock_flag;
            prdata_o <= next_prdata;
        end
    end

    // Formed from inputs so the register process does not read its own result
    assign osc_lost = osc_flag & ~oscrdy_rise & (pll_wr_req | oscrdy_fall);
    assign sel_changed = csr_wr & (pwdata_i[`CSR_TICK_SEL] != tick_clock_select);
    assign irq_o = |(irq_status & irq_mask);
    assign pll_locked_o = lock_flag;
    assign osc_up_flag_o = osc_flag;
    assign fm_amplitude_o = pll_modulation_control[`FM_HI_BIT:`FM_LO_BIT];

    // Prescaler base from rate code
    always_comb
    begin
        tick_base = 18'h00000;
        if (tick_rate_control[`DEC_BIT])
        begin
            unique case (tick_rate_control[`PRE_MSB:`PRE_LSB])
                3'h0: tick_base = 18'd1000;
                3'h1: tick_base = 18'd2000;
                3'h2: tick_base = 18'd5000;
                3'h3: tick_base = 18'd10000;
                3'h4: tick_base = 18'd20000;
                3'h5: tick_base = 18'd50000;
                3'h6: tick_base = 18'd100000;
                3'h7: tick_base = 18'd200000;
            endcase
        end
        else if (tick_rate_control[`PRE_MSB:`PRE_LSB] != 3'h0)
        begin
            tick_base = 18'h00001 << (`BIN_EXP_OFFSET + {2'b00, tick_rate_control[`PRE_MSB:`PRE_LSB]});
        end
    end

    assign tick_target = {4'h0, tick_base} * {17'h0, {1'b0, tick_rate_control[`MOD_MSB:`MOD_LSB]} + 5'h01};
    assign tick_src_edge = tick_clock_select ? osc_rise : irc_rise;
    assign tick_restart = tick_wr | sel_changed | osc_lost;

    // Timer mode
    always_comb
    begin
        if (tick_rate_control[`DEC_BIT:`PRE_LSB] == 4'h0)
        begin
            tick_mode = TICK_OFF;
        end
        else if (stop_mode_i && !(pseudo_stop_select && tick_clock_select))
        begin
            tick_mode = TICK_HALT;
        end
        else
        begin
            tick_mode = TICK_RUN;
        end
    end

    // Tick counter
    always_comb
    begin
        next_tick_cnt = tick_cnt;
        next_tick_event = 1'b0;
        unique case (tick_mode)
            TICK_OFF: next_tick_cnt = 22'h000000;
            TICK_HALT: next_tick_cnt = tick_cnt;
            TICK_RUN:
            begin
                if (tick_src_edge)
                begin
                    if (tick_cnt >= tick_target - 22'h000001)
                    begin
                        next_tick_cnt = 22'h000000;
                        next_tick_event = 1'b1;
                    end
                    else
                    begin
                        next_tick_cnt = tick_cnt + 22'h000001;
                    end
                end
            end
            default: next_tick_cnt = 22'h000000;
        endcase
        if (tick_restart)
        begin
            next_tick_cnt = 22'h000000;
            next_tick_event = 1'b0;
        end
    end

    // Modulation phase, one flip per eight reference edges
    always_comb
    begin
        next_fm_div = fm_div;
        next_fm_phase = fm_phase_o;
        if (pll_modulation_control[`FM_HI_BIT:`FM_LO_BIT] == FM_OFF)
        begin
            next_fm_div = 3'h0;
            next_fm_phase = 1'b0;
        end
        else if (ref_rise)
        begin
            next_fm_div = fm_div + 3'h1;
            if (fm_div == `FM_HALF_LAST)
            begin
                next_fm_phase = ~fm_phase_o;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            tick_cnt <= 22'h000000;
            tick_event_o <= 1'b0;
            fm_div <= 3'h0;
            fm_phase_o <= 1'b0;
        end
        else
        begin
            tick_cnt <= next_tick_cnt;
            tick_event_o <= next_tick_event;
            fm_div <= next_fm_div;
            fm_phase_o <= next_fm_phase;
        end
    end

    // Checks
    property p_pll_guard;
        @(posedge clk_i) disable iff (!nrst_i)
        pll_wr_req && (register_protect || !pll_clock_select) |=> $stable(pll_modulation_control);
    endproperty
    a_pll_guard: assert property (p_pll_guard) else $error("PLL write landed while guarded");

    property p_pll_clears;
        @(posedge clk_i) disable iff (!nrst_i)
        pll_wr_req && !oscrdy_rise && !lock_rise |=> !osc_flag && !lock_flag;
    endproperty
    a_pll_clears: assert property (p_pll_clears) else $error("PLL write kept status flags");

    property p_fm_rate;
        @(posedge clk_i) disable iff (!nrst_i)
        ref_rise && fm_div == 3'h7 && fm_amplitude_o != 2'b00 && $stable(fm_amplitude_o)
        |=> fm_phase_o != $past(fm_phase_o) && fm_div == 3'h0;
    endproperty
    a_fm_rate: assert property (p_fm_rate) else $error("Modulation phase missed its flip");

    property p_fm_off;
        @(posedge clk_i) disable iff (!nrst_i)
        fm_amplitude_o == 2'b00 |=> !fm_phase_o;
    endproperty
    a_fm_off: assert property (p_fm_off) else $error("Modulation active while off");

    property p_tick_source;
        @(posedge clk_i) disable iff (!nrst_i)
        !tick_src_edge && !tick_restart && tick_mode == TICK_RUN |=> $stable(tick_cnt) && !tick_event_o;
    endproperty
    a_tick_source: assert property (p_tick_source) else $error("Tick advanced without source edge");

    property p_tick_halt;
        @(posedge clk_i) disable iff (!nrst_i)
        stop_mode_i && !(pseudo_stop_select && tick_clock_select) && !tick_restart
        && tick_rate_control[7:4] != 4'h0 |=> $stable(tick_cnt);
    endproperty
    a_tick_halt: assert property (p_tick_halt) else $error("Tick counted in stop mode");

    property p_rate_write;
        @(posedge clk_i) disable iff (!nrst_i)
        tick_wr |=> tick_rate_control == $past(pwdata_i[7:0]) && tick_cnt == 22'h000000;
    endproperty
    a_rate_write: assert property (p_rate_write) else $error("Rate write lost or no restart");

    property p_sel_restart;
        @(posedge clk_i) disable iff (!nrst_i)
        sel_changed || osc_lost |=> tick_cnt == 22'h000000 && !tick_event_o;
    endproperty
    a_sel_restart: assert property (p_sel_restart) else $error("Clock change did not restart tick");

    property p_bin_base;
        @(posedge clk_i) disable iff (!nrst_i)
        tick_rate_control == 8'h10 |-> tick_target == 22'd1024;
    endproperty
    a_bin_base: assert property (p_bin_base) else $error("Binary prescaler wrong");

    property p_modulus;
        @(posedge clk_i) disable iff (!nrst_i)
        tick_rate_control == 8'hff |-> tick_target == 22'd3200000;
    endproperty
    a_modulus: assert property (p_modulus) else $error("Decimal divide with modulus wrong");

    property p_off;
        @(posedge clk_i) disable iff (!nrst_i)
        tick_rate_control[7:4] == 4'h0 ##1 tick_rate_control[7:4] == 4'h0 |-> tick_cnt == 22'h000000 && !tick_event_o;
    endproperty
    a_off: assert property (p_off) else $error("Tick timer ran while off");

    property p_wrap;
        @(posedge clk_i) disable iff (!nrst_i)
        tick_event_o |-> tick_cnt == 22'h000000 ##1 !tick_event_o;
    endproperty
    a_wrap: assert property (p_wrap) else $error("Tick event without period restart");

endmodule // tick_pll_ctrl

// File: periodic_tick_and_pll_fm_control_bench.sv
/*
 * Self-checking bench of tick_pll_ctrl: registers over APB, modulation,
 * tick periods, stop mode and tick interrupt.
 * Assumes tick_map.svh and tick_pkg are compiled with it.
 */
`timescale 1ns/10ps
`include "tick_map.svh"
module periodic_tick_and_pll_fm_control_bench
    import tick_pkg::*;
;
    logic clk_i, nrst_i, psel_i, penable_i, pwrite_i, stop_i, osc_i, lock_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o;
    logic [3:0] pstrb_i;
    logic pready_o, pslverr_o, fm_phase_o, tick_event_o, irq_o, pll_locked_o, osc_up_flag_o;
    logic [1:0] fm_amplitude_o;
    logic rc_i = 0, xt_i = 0, ref_i = 0, rc_run = 1, xt_run = 0;
    logic [2:0] ph = 3'h0;
    logic [3:0] strb = 4'hf;
    int fail_count = 0, total_checks = 0;

    tick_pll_ctrl dut (.clk_i(clk_i), .nrst_i(nrst_i), .paddr_i(paddr_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .internal_rc_clock_i(rc_i), .crystal_osc_clock_i(xt_i), .pll_ref_clock_i(ref_i),
        .osc_ready_i(osc_i), .pll_lock_i(lock_i), .stop_mode_i(stop_i),
        .fm_amplitude_o(fm_amplitude_o), .fm_phase_o(fm_phase_o), .tick_event_o(tick_event_o),
        .irq_o(irq_o), .pll_locked_o(pll_locked_o), .osc_up_flag_o(osc_up_flag_o));

    initial
    begin
        clk_i = 0;
        forever #25 clk_i = ~clk_i;
    end

    // Slow source clocks: six block cycles each, three high
    always @(posedge clk_i)
    begin
        ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
        rc_i <= rc_run && ph < 3'h3;
        xt_i <= xt_run && ph < 3'h3;
        ref_i <= ph < 3'h3;
    end

    task test_done;
        if (fail_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task chk_rng(input int got, input int lo, input int hi);
        total_checks++;
        if (got < lo || got > hi)
        begin
            fail_count++;
            $display("CHECK FAILED %0t count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask

    task apb(input logic [11:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        paddr_i <= a;
        pwrite_i <= w;
        pwdata_i <= d;
        pstrb_i <= strb;
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        while (pready_o !== 1'b1)
            @(posedge clk_i);
        q = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(a, 1'b1, d, q, e);
    endtask

    task rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        apb(a, 1'b0, 32'h0, q, e);
        chk(q, exp);
    endtask

    task wait_tick(input int lim, output int c);
        c = 0;
        do
        begin
            @(posedge clk_i);
            c++;
        end
        while (tick_event_o !== 1'b1 && c < lim);
    endtask

    task no_tick(input int n);
        int c;
        wait_tick(n, c);
        chk_rng(c, n, n);
    endtask

    // Optional second write after pre cycles must restart the period
    task measure(input logic [7:0] rate, input int n, input int pre);
        int c;
        wr(`TRC_ADDR, {24'h0, rate});
        if (pre > 0)
        begin
            repeat (pre) @(posedge clk_i);
            wr(`TRC_ADDR, {24'h0, rate});
        end
        wait_tick(n * 6 + 40, c);
        chk_rng(c, n * 6 - 8, n * 6 + 12);
    endtask

    task t_reset;
        logic [31:0] q;
        logic e;
        rd(`PMC_ADDR, 32'h0);
        rd(`TRC_ADDR, 32'h0);
        apb(12'h100, 1'b0, 32'h0, q, e);
        chk({31'h0, e}, 32'h1);
        wr(`TRC_ADDR, 32'h0f);
        rd(`TRC_ADDR, 32'h0f);
        no_tick(2000);
        // Longest divide; a write without byte 0 strobe is ignored
        wr(`TRC_ADDR, 32'hff);
        strb = 4'he;
        wr(`TRC_ADDR, 32'h05);
        strb = 4'hf;
        rd(`TRC_ADDR, 32'hff);
    endtask

    task t_pll;
        chk({30'h0, pll_locked_o, osc_up_flag_o}, 32'h3);
        wr(`PMC_ADDR, 32'h30);
        rd(`PMC_ADDR, 32'h0);
        chk({30'h0, pll_locked_o, osc_up_flag_o}, 32'h0);
        wr(`CSR_ADDR, 32'h08);
        for (int i = 0; i < 4; i++)
        begin
            wr(`PMC_ADDR, i << 4);
            rd(`PMC_ADDR, i << 4);
            chk({30'h0, fm_amplitude_o}, i);
        end
        wr(`CSR_ADDR, 32'h0c);
        wr(`PMC_ADDR, 32'h10);
        rd(`PMC_ADDR, 32'h30);
        wr(`CSR_ADDR, 32'h08);
    endtask

    task t_fm;
        logic p;
        int c;
        repeat (2)
        begin
            p = fm_phase_o;
            c = 0;
            while (fm_phase_o === p && c < 200)
            begin
                @(posedge clk_i);
                c++;
            end
        end
        chk_rng(c, 48, 48);
    endtask

    task t_tick;
        logic [31:0] q;
        logic e;
        wr(`IMK_ADDR, 32'h1);
        measure(8'h10, 1024, 0);
        repeat (2) @(posedge clk_i);
        chk({31'h0, irq_o}, 32'h1);
        apb(`IST_ADDR, 1'b0, 32'h0, q, e);
        chk(q & 32'h1, 32'h1);
        chk({31'h0, irq_o}, 32'h0);
        measure(8'h11, 2048, 0);
        measure(8'h20, 2048, 0);
        measure(8'h80, 1000, 0);
        measure(8'h90, 2000, 0);
        measure(8'h10, 1024, 3000);
    endtask

    task t_stop;
        int c;
        stop_i <= 1'b1;
        wr(`TRC_ADDR, 32'h10);
        no_tick(7000);
        osc_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        osc_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        wr(`CSR_ADDR, 32'h0b);
        rc_run <= 1'b0;
        xt_run <= 1'b1;
        measure(8'h10, 1024, 0);
        // Losing the oscillator mid-period must start a fresh period on RC
        stop_i <= 1'b0;
        rc_run <= 1'b1;
        repeat (3000) @(posedge clk_i);
        osc_i <= 1'b0;
        wait_tick(6184, c);
        chk_rng(c, 6136, 6160);
        rd(`CSR_ADDR, 32'h0a);
    endtask

    initial
    begin
        nrst_i = 0;
        psel_i = 0;
        penable_i = 0;
        pwrite_i = 0;
        paddr_i = 12'h0;
        pwdata_i = 32'h0;
        pstrb_i = 4'h0;
        stop_i = 0;
        osc_i = 0;
        lock_i = 0;
        repeat (20) @(posedge clk_i);
        nrst_i <= 1'b1;
        osc_i <= 1'b1;
        lock_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        t_reset;
        t_pll;
        t_fm;
        t_tick;
        t_stop;
        test_done;
    end

    // Watchdog well beyond the expected run length
    initial
    begin
        repeat (95000) @(posedge clk_i);
        fail_count++;
        test_done;
    end
endmodule // periodic_tick_and_pll_fm_control_bench
